// *** design/mfpp_defines.vh ***
// Constants of the forward packet parser: packet layout, codes and timing.
`ifndef MFPP_DEFINES_VH
`define MFPP_DEFINES_VH

// ==========================================
// Packet types and fixed words
`define MFPP_TYPE_HDR 16'h03bf
`define MFPP_TYPE_REG 16'h0092
`define MFPP_TYPE_VID 16'h0010
`define MFPP_TYPE_FILL 16'h0000
`define MFPP_UNIQUE_WORD 16'h005a
`define MFPP_RW_WRITE 16'h0000
`define MFPP_RW_READ 16'hc000
`define MFPP_FMT_18B 16'h5666
`define MFPP_FMT_16B 16'h5565
`define MFPP_PIX_ATTR 16'h0023
`define MFPP_PIX_MAX 16'hffe5

// ==========================================
// Packet lengths (bytes after the length field)
`define MFPP_LEN_HDR 16'h0014
`define MFPP_LEN_REG 16'h0012
`define MFPP_LEN_VID_MIN 16'h001a
`define MFPP_LEN_FILL_MIN 16'h0004
// Header bits as they arrive: length, type, unique word, low byte first
`define MFPP_HDR_PATTERN 48'h005a_03bf_0014

// ==========================================
// Field byte indices, counted from the first length byte
`define MFPP_IX_CLIENT 6'h05
`define MFPP_IX_RSV 6'h07
`define MFPP_IX_FMT 6'h07
`define MFPP_IX_RW 6'h07
`define MFPP_IX_ATTR 6'h09
`define MFPP_IX_ADDR_LO 6'h09
`define MFPP_IX_ADDR_HI 6'h0b
`define MFPP_IX_SFLEN_LO 6'h09
`define MFPP_IX_SFLEN_HI 6'h0b
`define MFPP_IX_VER 6'h0d
`define MFPP_IX_SFCNT 6'h0f
`define MFPP_IX_MFCNT_LO 6'h11
`define MFPP_IX_MFCNT_HI 6'h13
`define MFPP_IX_REG_PCRC 6'h0d
`define MFPP_IX_DATA_LO 6'h0f
`define MFPP_IX_DATA_HI 6'h11
`define MFPP_IX_PIXCNT 6'h17
`define MFPP_IX_VID_PCRC 6'h19
`define MFPP_IX_PIX_FIRST 6'h1a

// ==========================================
// CRC and timing
`define MFPP_CRC_INIT 16'hffff
`define MFPP_CRC_POLY 16'h1021
`define MFPP_IDLE_STB_CYC 8'h28
`define MFPP_IDLE_BITS (`MFPP_IDLE_STB_CYC * 8'h02)

`endif

// *** design/mfpp_crc16.v ***
// Running 16-bit packet CRC, fed one byte at a time, low bit first.
`timescale 1ns/10ps
`default_nettype none
`include "mfpp_defines.vh"

module mfpp_crc16 (
	input wire clk,
	input wire nrst,
	input wire seed,
	input wire clr,
	input wire feed,
	input wire [7:0] data,
	output wire [15:0] crc
);

	function [15:0] mfpp_crc_byte;
		input [15:0] c;
		input [7:0] d;
		integer i;
		reg [15:0] r;
		reg fb;
		begin
			r = c;
			for (i = 0; i < 8; i = i + 1) begin
				fb = r[15] ^ d[i];
				r = {r[14:0], 1'b0} ^ (fb ? `MFPP_CRC_POLY : 16'h0000);
			end
			mfpp_crc_byte = r;
		end
	endfunction

	reg [15:0] crc_q;
	wire [15:0] base = clr ? `MFPP_CRC_INIT : crc_q;
	// The header's first six bytes are eaten by the aligner, so start from their CRC
	wire [15:0] seed_val = mfpp_crc_byte(mfpp_crc_byte(mfpp_crc_byte(mfpp_crc_byte(
		mfpp_crc_byte(mfpp_crc_byte(`MFPP_CRC_INIT, 8'h14), 8'h00), 8'hbf), 8'h03),
		8'h5a), 8'h00);

	always @(posedge clk) begin
		if (!nrst)
			crc_q <= `MFPP_CRC_INIT;
		else if (seed)
			crc_q <= seed_val;
		else if (feed)
			crc_q <= mfpp_crc_byte(base, data);
		else if (clr)
			crc_q <= `MFPP_CRC_INIT;
	end

	assign crc = crc_q;

endmodule // mfpp_crc16
`default_nettype wire

// *** design/mfpp_link_rx.v ***
// Data-strobe link receiver: pin sync, bit recovery, idle wait, header hunt, bytes.
`timescale 1ns/10ps
`default_nettype none
`include "mfpp_defines.vh"

module mfpp_link_rx #(
	parameter [7:0] IDLE_BITS = `MFPP_IDLE_BITS
) (
	input wire clk,
	input wire nrst,
	input wire data_pin,
	input wire stb_pin,
	input wire resync,
	output reg byte_valid,
	output reg [7:0] byte_data,
	output reg sync_hit,
	output reg aligned
);

	reg d_m_q, d_s_q, s_m_q, s_s_q, x_q;
	reg [7:0] idle_q;
	reg armed_q;
	reg [47:0] sr_q;
	reg [2:0] bit_q;
	reg [7:0] sh_q;

	// Every bit flips data xor strobe exactly once
	wire x_now = d_s_q ^ s_s_q;
	wire bit_ev = x_now ^ x_q;
	wire [47:0] sr_in = {d_s_q, sr_q[47:1]};

	always @(posedge clk) begin
		if (!nrst) begin
			d_m_q <= 1'b0;
			d_s_q <= 1'b0;
			s_m_q <= 1'b0;
			s_s_q <= 1'b0;
			x_q <= 1'b0;
			idle_q <= 8'h00;
			armed_q <= 1'b0;
			sr_q <= 48'h0000_0000_0000;
			bit_q <= 3'h0;
			sh_q <= 8'h00;
			byte_valid <= 1'b0;
			byte_data <= 8'h00;
			sync_hit <= 1'b0;
			aligned <= 1'b0;
		end else begin
			d_m_q <= data_pin;
			d_s_q <= d_m_q;
			s_m_q <= stb_pin;
			s_s_q <= s_m_q;
			x_q <= x_now;
			byte_valid <= 1'b0;
			sync_hit <= 1'b0;
			if (resync) begin
				// Mid-stream loss keeps searching; the idle wait is only for restart
				aligned <= 1'b0;
				armed_q <= 1'b1;
			end else if (bit_ev && !aligned) begin
				sr_q <= sr_in;
				if (d_s_q)
					idle_q <= 8'h00;
				else if (idle_q != IDLE_BITS)
					idle_q <= idle_q + 8'h01;
				if (idle_q == IDLE_BITS)
					armed_q <= 1'b1;
				if (armed_q && sr_in == `MFPP_HDR_PATTERN) begin
					aligned <= 1'b1;
					sync_hit <= 1'b1;
					bit_q <= 3'h0;
				end
			end else if (bit_ev) begin
				sh_q <= {d_s_q, sh_q[7:1]};
				bit_q <= bit_q + 3'h1;
				if (bit_q == 3'h7) begin
					byte_valid <= 1'b1;
					byte_data <= {d_s_q, sh_q[7:1]};
				end
			end
		end
	end

endmodule // mfpp_link_rx
`default_nettype wire

// *** design/mfpp_parser.v ***
// Forward-link packet parser: header, register access, video stream and filler.
`timescale 1ns/10ps
`default_nettype none
`include "mfpp_defines.vh"

module mfpp_parser #(
	parameter [7:0] IDLE_BITS = `MFPP_IDLE_BITS
) (
	input wire clk,
	input wire nrst,
	input wire mddi_data,
	input wire mddi_stb,
	output reg in_sync_q,
	output reg sof_q,
	output reg [31:0] sf_len_q,
	output reg [15:0] sf_count_q,
	output reg [31:0] mf_count_q,
	output reg reg_wr_q,
	output reg reg_rd_q,
	output reg [31:0] reg_addr_q,
	output reg [31:0] reg_data_q,
	output reg pix_valid_q,
	output reg [17:0] pix_data_q,
	output reg pix_18b_q,
	output reg crc_err_q,
	output reg pkt_err_q
);

	// ==========================================
	// States
	localparam [2:0] ST_HUNT = 3'h0;
	localparam [2:0] ST_LEN = 3'h1;
	localparam [2:0] ST_TYPE = 3'h2;
	localparam [2:0] ST_HDR = 3'h3;
	localparam [2:0] ST_REG = 3'h4;
	localparam [2:0] ST_VID = 3'h5;
	localparam [2:0] ST_FILL = 3'h6;
	localparam [2:0] ST_SKIP = 3'h7;

	reg [2:0] state_q;
	reg [5:0] idx_q;
	reg [15:0] rem_q;
	reg [7:0] lo_q;
	reg bad_q;
	reg pok_q;
	reg rd_q;
	reg resync_q;
	reg [15:0] pix_left_q;
	reg [25:0] acc_q;
	reg [4:0] nb_q;
	reg [31:0] addr_t_q;
	reg [31:0] data_t_q;
	reg [31:0] sflen_t_q;
	reg [15:0] sfc_t_q;
	reg [15:0] mfc_lo_q;

	wire byte_valid;
	wire [7:0] byte_data;
	wire sync_hit;
	wire aligned;
	wire [15:0] crc_val;

	// ==========================================
	// Link receiver and CRC
	mfpp_link_rx #(
		.IDLE_BITS(IDLE_BITS)
	) u_rx (
		.clk(clk),
		.nrst(nrst),
		.data_pin(mddi_data),
		.stb_pin(mddi_stb),
		.resync(resync_q),
		.byte_valid(byte_valid),
		.byte_data(byte_data),
		.sync_hit(sync_hit),
		.aligned(aligned)
	);

	// Byte pairs, low byte first
	wire [15:0] word = {byte_data, lo_q};
	wire last = (rem_q == 16'h0001);
	wire tail = (rem_q <= 16'h0002) && (state_q != ST_LEN) && (state_q != ST_TYPE);
	wire crc_ok = (word == crc_val);
	wire pcrc_reg = (state_q == ST_REG) && (idx_q == 6'h0c || idx_q == `MFPP_IX_REG_PCRC);
	wire pcrc_vid = (state_q == ST_VID) && (idx_q == 6'h18 || idx_q == `MFPP_IX_VID_PCRC);
	wire crc_clr = byte_valid && ((state_q == ST_LEN && idx_q == 6'h00) ||
		(state_q == ST_REG && idx_q == `MFPP_IX_REG_PCRC) ||
		(state_q == ST_VID && idx_q == `MFPP_IX_VID_PCRC));
	wire crc_feed = byte_valid && !tail && !pcrc_reg && !pcrc_vid;

	mfpp_crc16 u_crc (
		.clk(clk),
		.nrst(nrst),
		.seed(sync_hit),
		.clr(crc_clr),
		.feed(crc_feed),
		.data(byte_data),
		.crc(crc_val)
	);

	// ==========================================
	// Pixel unpacking: packed pixels run straight across byte edges
	wire [4:0] pw = pix_18b_q ? 5'h12 : 5'h10;
	wire [25:0] acc_in = acc_q | ({18'h0_0000, byte_data} << nb_q);
	wire [4:0] nb_in = nb_q + 5'h08;
	wire pix_byte = (state_q == ST_VID) && (idx_q >= `MFPP_IX_PIX_FIRST) && !tail;

	// ==========================================
	// Packet walk
	always @(posedge clk) begin
		if (!nrst) begin
			state_q <= ST_HUNT;
			idx_q <= 6'h00;
			rem_q <= 16'h0000;
			lo_q <= 8'h00;
			bad_q <= 1'b0;
			pok_q <= 1'b0;
			rd_q <= 1'b0;
			resync_q <= 1'b0;
			pix_left_q <= 16'h0000;
			acc_q <= 26'h000_0000;
			nb_q <= 5'h00;
			addr_t_q <= 32'h0000_0000;
			data_t_q <= 32'h0000_0000;
			sflen_t_q <= 32'h0000_0000;
			sfc_t_q <= 16'h0000;
			mfc_lo_q <= 16'h0000;
			in_sync_q <= 1'b0;
			sof_q <= 1'b0;
			sf_len_q <= 32'h0000_0000;
			sf_count_q <= 16'h0000;
			mf_count_q <= 32'h0000_0000;
			reg_wr_q <= 1'b0;
			reg_rd_q <= 1'b0;
			reg_addr_q <= 32'h0000_0000;
			reg_data_q <= 32'h0000_0000;
			pix_valid_q <= 1'b0;
			pix_data_q <= 18'h0_0000;
			pix_18b_q <= 1'b0;
			crc_err_q <= 1'b0;
			pkt_err_q <= 1'b0;
		end else begin
			in_sync_q <= aligned;
			sof_q <= 1'b0;
			reg_wr_q <= 1'b0;
			reg_rd_q <= 1'b0;
			pix_valid_q <= 1'b0;
			crc_err_q <= 1'b0;
			pkt_err_q <= 1'b0;
			resync_q <= 1'b0;
			if (state_q == ST_HUNT) begin
				if (sync_hit) begin
					state_q <= ST_HDR;
					idx_q <= 6'h06;
					rem_q <= `MFPP_LEN_HDR - 16'h0004;
					bad_q <= 1'b0;
				end
			end else if (byte_valid) begin
				lo_q <= byte_data;
				if (idx_q != 6'h3f)
					idx_q <= idx_q + 6'h01;
				rem_q <= rem_q - 16'h0001;
				if (last) begin
					state_q <= ST_LEN;
					idx_q <= 6'h00;
				end
				case (state_q)
					ST_LEN: begin
						if (idx_q == 6'h01) begin
							rem_q <= word;
							state_q <= ST_TYPE;
						end
					end
					ST_TYPE: begin
						bad_q <= 1'b0;
						pok_q <= 1'b0;
						if (idx_q == 6'h03 && !last) begin
							state_q <= ST_SKIP;
							if (word == `MFPP_TYPE_HDR) begin
								state_q <= ST_HDR;
								if (rem_q != `MFPP_LEN_HDR - 16'h0001) begin
									pkt_err_q <= 1'b1;
									resync_q <= 1'b1;
									state_q <= ST_HUNT;
								end
							end else if (word == `MFPP_TYPE_REG) begin
								state_q <= ST_REG;
								if (rem_q != `MFPP_LEN_REG - 16'h0001) begin
									pkt_err_q <= 1'b1;
									state_q <= ST_SKIP;
								end
							end else if (word == `MFPP_TYPE_VID) begin
								state_q <= ST_VID;
								if (rem_q < `MFPP_LEN_VID_MIN - 16'h0001) begin
									pkt_err_q <= 1'b1;
									state_q <= ST_SKIP;
								end
							end else if (word == `MFPP_TYPE_FILL) begin
								state_q <= ST_FILL;
								if (rem_q < `MFPP_LEN_FILL_MIN - 16'h0001) begin
									pkt_err_q <= 1'b1;
									state_q <= ST_SKIP;
								end
							end
						end
					end
					ST_HDR: begin
						if (idx_q == `MFPP_IX_CLIENT && word != `MFPP_UNIQUE_WORD)
							bad_q <= 1'b1;
						if ((idx_q == `MFPP_IX_RSV || idx_q == `MFPP_IX_VER) && word != 16'h0000)
							bad_q <= 1'b1;
						if (idx_q == `MFPP_IX_SFLEN_LO)
							sflen_t_q[15:0] <= word;
						if (idx_q == `MFPP_IX_SFLEN_HI)
							sflen_t_q[31:16] <= word;
						if (idx_q == `MFPP_IX_SFCNT)
							sfc_t_q <= word;
						if (idx_q == `MFPP_IX_MFCNT_LO)
							mfc_lo_q <= word;
						if (idx_q == `MFPP_IX_MFCNT_HI)
							mf_count_q[31:16] <= word;
						if (last) begin
							if (crc_ok && !bad_q) begin
								sof_q <= 1'b1;
								sf_len_q <= sflen_t_q;
								sf_count_q <= sfc_t_q;
								mf_count_q[15:0] <= mfc_lo_q;
							end else begin
								crc_err_q <= !crc_ok;
								pkt_err_q <= bad_q;
								resync_q <= 1'b1;
								state_q <= ST_HUNT;
							end
						end
					end
					ST_REG: begin
						if (idx_q == `MFPP_IX_CLIENT && word != 16'h0000)
							bad_q <= 1'b1;
						if (idx_q == `MFPP_IX_RW) begin
							rd_q <= (word == `MFPP_RW_READ);
							if (word != `MFPP_RW_READ && word != `MFPP_RW_WRITE)
								bad_q <= 1'b1;
						end
						if (idx_q == `MFPP_IX_ADDR_LO)
							addr_t_q[15:0] <= word;
						if (idx_q == `MFPP_IX_ADDR_HI)
							addr_t_q[31:16] <= word;
						if (idx_q == `MFPP_IX_REG_PCRC && !crc_ok) begin
							crc_err_q <= 1'b1;
							bad_q <= 1'b1;
						end
						if (idx_q == `MFPP_IX_DATA_LO)
							data_t_q[15:0] <= word;
						if (idx_q == `MFPP_IX_DATA_HI)
							data_t_q[31:16] <= word;
						if (last) begin
							if (crc_ok && !bad_q) begin
								reg_wr_q <= !rd_q;
								reg_rd_q <= rd_q;
								reg_addr_q <= addr_t_q;
								reg_data_q <= data_t_q;
							end else if (!crc_ok) begin
								crc_err_q <= 1'b1;
							end else begin
								pkt_err_q <= 1'b1;
							end
						end
					end
					ST_VID: begin
						if (idx_q == `MFPP_IX_CLIENT && word != 16'h0000)
							bad_q <= 1'b1;
						if (idx_q == `MFPP_IX_FMT) begin
							pix_18b_q <= (word == `MFPP_FMT_18B);
							if (word != `MFPP_FMT_18B && word != `MFPP_FMT_16B)
								bad_q <= 1'b1;
						end
						if (idx_q == `MFPP_IX_ATTR && word != `MFPP_PIX_ATTR)
							bad_q <= 1'b1;
						if (idx_q == `MFPP_IX_PIXCNT) begin
							pix_left_q <= word;
							if (word > `MFPP_PIX_MAX)
								bad_q <= 1'b1;
						end
						if (idx_q == `MFPP_IX_VID_PCRC) begin
							pok_q <= crc_ok && !bad_q;
							crc_err_q <= !crc_ok;
							pkt_err_q <= crc_ok && bad_q;
							acc_q <= 26'h000_0000;
							nb_q <= 5'h00;
						end
						if (pix_byte && pok_q && pix_left_q != 16'h0000) begin
							if (nb_in >= pw) begin
								pix_valid_q <= 1'b1;
								pix_data_q <= pix_18b_q ? acc_in[17:0] : {2'b00, acc_in[15:0]};
								acc_q <= acc_in >> pw;
								nb_q <= nb_in - pw;
								pix_left_q <= pix_left_q - 16'h0001;
							end else begin
								acc_q <= acc_in;
								nb_q <= nb_in;
							end
						end
						if (last && pok_q && !crc_ok)
							crc_err_q <= 1'b1;
					end
					ST_FILL: begin
						if (!tail && byte_data != 8'h00)
							bad_q <= 1'b1;
						if (last) begin
							crc_err_q <= !crc_ok;
							pkt_err_q <= crc_ok && bad_q;
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

endmodule // mfpp_parser
`default_nettype wire

// *** testbench/mfpp_host_model.sv ***
// Host end of the link: sends data-strobe coded bits and keeps the running CRC.
`timescale 1ns/10ps
`default_nettype none

module mfpp_host_model (
	input wire logic clk,
	output logic data,
	output logic stb
);
	logic [15:0] crc;

	initial begin
		data = 1'b0;
		stb = 1'b0;
		crc = 16'hffff;
	end

	// ==================
	// Senders, one bit every four clocks
	// bits low first, CRC
	task automatic send_bit(input logic b);
		data <= b;
		stb <= b ^ ~(data ^ stb);
		crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? 16'h1021 : 16'h0000);
		repeat (4) @(posedge clk);
	endtask

	task automatic idle(input int n);
		for (int i = 0; i < n; i++)
			send_bit(1'b0);
		crc = 16'hffff;
	endtask

	task automatic send_byte(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
			send_bit(v[i]);
	endtask

	task automatic send16(input logic [15:0] v);
		send_byte(v[7:0]);
		send_byte(v[15:8]);
	endtask

	task automatic send32(input logic [31:0] v);
		send16(v[15:0]);
		send16(v[31:16]);
	endtask

	task automatic send_crc(input logic bad);
		logic [15:0] v;
		v = crc ^ {15'h0000, bad};
		send16(v);
		crc = 16'hffff;
	endtask
endmodule // mfpp_host_model
`default_nettype wire

// *** testbench/mfpp_parser_chk.sv ***
// Port assertions for the forward packet parser.
`timescale 1ns/10ps
`default_nettype none

module mfpp_parser_chk #(
	parameter [7:0] IDLE_BITS = 8'h50
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic mddi_data,
	input wire logic mddi_stb,
	input wire logic in_sync_q,
	input wire logic sof_q,
	input wire logic [31:0] sf_len_q,
	input wire logic [15:0] sf_count_q,
	input wire logic [31:0] mf_count_q,
	input wire logic reg_wr_q,
	input wire logic reg_rd_q,
	input wire logic [31:0] reg_addr_q,
	input wire logic [31:0] reg_data_q,
	input wire logic pix_valid_q,
	input wire logic [17:0] pix_data_q,
	input wire logic pix_18b_q,
	input wire logic crc_err_q,
	input wire logic pkt_err_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	logic any_pulse;
	assign any_pulse = sof_q | reg_wr_q | reg_rd_q | pix_valid_q;

	// ==================
	// Assertions
	reset_clear_a: assert property (disable iff (1'b0) !nrst |=>
		!(any_pulse | crc_err_q | pkt_err_q | in_sync_q)) else $error("not cleared by reset");
	rw_exclusive_a: assert property (!(reg_wr_q && reg_rd_q))
		else $error("read and write together");
	wr_single_a: assert property (reg_wr_q |=> !reg_wr_q)
		else $error("write pulse too long");
	sof_aligned_a: assert property (sof_q |-> in_sync_q && $past(in_sync_q, 8))
		else $error("header seen while unaligned");
	access_hold_a: assert property (!$stable(reg_addr_q) || !$stable(reg_data_q)
		|-> reg_wr_q || reg_rd_q) else $error("access fields moved");
	sf_hold_a: assert property (!$stable(sf_len_q) || !$stable(sf_count_q) |-> sof_q)
		else $error("header fields moved");
	pix_hold_a: assert property (!$stable(pix_data_q) |-> pix_valid_q)
		else $error("pixel moved without strobe");
	pix16_pad_a: assert property (pix_valid_q && !pix_18b_q |-> pix_data_q[17:16] == 2'b00)
		else $error("16-bit pixel top bits set");
	crc_veto_a: assert property (crc_err_q |-> !(reg_wr_q || reg_rd_q || sof_q))
		else $error("bad CRC packet reported");
	link_quiet_a: assert property ($stable({mddi_data, mddi_stb}) [*8] |=> !any_pulse)
		else $error("pulse without link traffic");

	cover property (sof_q);
	cover property (reg_rd_q);
	cover property (pix_valid_q && pix_18b_q);
	cover property (crc_err_q);
endmodule // mfpp_parser_chk
`default_nettype wire

// *** testbench/test_mddi_forward_packet_parser.sv ***
// Self-checking bench for the forward packet parser driven by a host link model.
`timescale 1ns/10ps
`default_nettype none

module test_mddi_forward_packet_parser;
	// Below the zero run of a header's reserved word, so a header can arm the hunt, but only after its own pattern
	localparam logic [7:0] IDLE = 8'h10;
	typedef struct packed {logic [15:0] rw; logic [31:0] a; logic [31:0] d; logic bad;} mfpp_row_t;
	logic clk, nrst, ok;
	wire mddi_data, mddi_stb;
	logic in_sync_q, sof_q, reg_wr_q, reg_rd_q, pix_valid_q, pix_18b_q, crc_err_q, pkt_err_q;
	logic [31:0] sf_len_q, mf_count_q, reg_addr_q, reg_data_q;
	logic [15:0] sf_count_q;
	logic [17:0] pix_data_q;
	logic [31:0] la = 32'h0, ld = 32'h0;
	logic [17:0] pix_q[$];
	int n_mismatch = 0, tests_run = 0, cyc = 0;
	int n_sof = 0, n_wr = 0, n_rd = 0, n_ce = 0, n_pe = 0;
	mfpp_row_t rows[8] = '{
		'{16'h0000, 32'h0000_0010, 32'h1234_5678, 1'b0},
		'{16'hc000, 32'hffff_ffff, 32'h0000_0000, 1'b0},
		'{16'h0000, 32'h0000_0000, 32'hffff_ffff, 1'b0},
		'{16'h0000, 32'h0000_0022, 32'hdead_beef, 1'b1},
		'{16'h4000, 32'h0000_0033, 32'h0000_0001, 1'b0},
		'{16'hc001, 32'h0000_0044, 32'h0000_0002, 1'b0},
		'{16'hc000, 32'h8000_0001, 32'ha5a5_5a5a, 1'b0},
		'{16'h8000, 32'h0000_0055, 32'h0000_0003, 1'b0}};

	mfpp_host_model u_host (.clk(clk), .data(mddi_data), .stb(mddi_stb));
	mfpp_parser #(.IDLE_BITS(IDLE)) DUT (.clk(clk), .nrst(nrst), .mddi_data(mddi_data),
		.mddi_stb(mddi_stb), .in_sync_q(in_sync_q), .sof_q(sof_q), .sf_len_q(sf_len_q),
		.sf_count_q(sf_count_q), .mf_count_q(mf_count_q), .reg_wr_q(reg_wr_q),
		.reg_rd_q(reg_rd_q), .reg_addr_q(reg_addr_q), .reg_data_q(reg_data_q),
		.pix_valid_q(pix_valid_q), .pix_data_q(pix_data_q), .pix_18b_q(pix_18b_q),
		.crc_err_q(crc_err_q), .pkt_err_q(pkt_err_q));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==================
	// Pulse counters and hang guard
	always @(posedge clk) begin
		cyc++;
		if (sof_q === 1'b1) n_sof++;
		if (reg_wr_q === 1'b1) n_wr++;
		if (reg_rd_q === 1'b1) n_rd++;
		if (crc_err_q === 1'b1) n_ce++;
		if (pkt_err_q === 1'b1) n_pe++;
		if (pix_valid_q === 1'b1) pix_q.push_back(pix_data_q);
		if (cyc == 30000) begin
			n_mismatch++;
			summarize();
		end
	end

	// ==================
	// Helpers
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic zero;
		#1;
		{n_sof, n_wr, n_rd, n_ce, n_pe} = '0;
		pix_q.delete();
		@(posedge clk);
	endtask
	task automatic settle;
		repeat (12) @(posedge clk);
		#1;
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic hdr(input logic [31:0] len, input logic [15:0] cnt, input logic [31:0] mf,
		input logic bad);
		u_host.send16(16'h0014);
		u_host.send16(16'h03bf);
		u_host.send16(16'h005a);
		u_host.send16(16'h0000);
		u_host.send32(len);
		u_host.send16(16'h0000);
		u_host.send16(cnt);
		u_host.send32(mf);
		u_host.send_crc(bad);
	endtask
	task automatic reg_pkt(input logic [15:0] rw, input logic [31:0] a, input logic [31:0] d,
		input logic bad);
		u_host.send16(16'h0012);
		u_host.send16(16'h0092);
		u_host.send16(16'h0000);
		u_host.send16(rw);
		u_host.send32(a);
		u_host.send_crc(1'b0);
		u_host.send32(d);
		u_host.send_crc(bad);
	endtask
	// video layout
	// Bad bit 1 spoils the parameter CRC, bit 0 the pixel CRC
	task automatic vid(input logic [15:0] fmt, input logic [15:0] n, input logic [39:0] px,
		input logic [1:0] bad);
		u_host.send16(16'h001f);
		u_host.send16(16'h0010);
		u_host.send16(16'h0000);
		u_host.send16(fmt);
		u_host.send16(16'h0023);
		for (int i = 0; i < 6; i++)
			u_host.send16(16'h0000);
		u_host.send16(n);
		u_host.send_crc(bad[1]);
		for (int i = 0; i < 5; i++)
			u_host.send_byte(px[8*i +: 8]);
		u_host.send_crc(bad[0]);
	endtask
	task automatic fill(input logic [7:0] b);
		u_host.send16(16'h0007);
		u_host.send16(16'h0000);
		u_host.send_byte(8'h00);
		u_host.send_byte(b);
		u_host.send_byte(8'h00);
		u_host.send_crc(1'b0);
	endtask
	task automatic sync(input logic [31:0] len, input logic [15:0] cnt, input logic [31:0] mf);
		zero();
		u_host.idle(24);
		hdr(len, cnt, mf, 1'b0);
		settle();
		check(n_sof, 1);
		check({sf_len_q, sf_count_q}, {len, cnt});
		check(mf_count_q, mf);
		check(in_sync_q, 1);
		done("sync");
	endtask

	// ==================
	// Main sequence
	initial begin
		nrst = 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		#1;
		check({in_sync_q, sof_q, reg_wr_q, reg_rd_q, pix_valid_q, crc_err_q}, 0);
		sync(32'h0001_2000, 16'h0001, 32'h0000_0005);
		foreach (rows[i]) begin
			zero();
			reg_pkt(rows[i].rw, rows[i].a, rows[i].d, rows[i].bad);
			settle();
			ok = !rows[i].bad && (rows[i].rw == 16'h0000 || rows[i].rw == 16'hc000);
			if (ok) begin
				la = rows[i].a;
				ld = rows[i].d;
			end
			check(n_wr, ok && rows[i].rw == 16'h0000);
			check(n_rd, ok && rows[i].rw == 16'hc000);
			check(n_ce, rows[i].bad);
			check(n_pe, !rows[i].bad && !ok);
			check(reg_addr_q, la);
			check(reg_data_q, ld);
			done("row");
		end
		zero();
		vid(16'h5565, 16'h0002, 40'hff_beef_1234, 2'b01);
		settle();
		check(pix_q.size(), 2);
		check({pix_q[1], pix_q[0]}, {18'h0_beef, 18'h0_1234});
		check({pix_18b_q, n_ce}, 1);
		zero();
		vid(16'h5666, 16'h0002, {4'hf, 18'h1_5a3c, 18'h2_a5c3}, 2'b00);
		settle();
		check({pix_q[1], pix_q[0]}, {18'h1_5a3c, 18'h2_a5c3});
		check(pix_18b_q, 1);
		check({n_ce, pix_q.size()}, {32'h0, 32'h2});
		zero();
		vid(16'h5565, 16'hffe6, 40'h0, 2'b00);
		settle();
		check({n_pe, pix_q.size()}, {32'h1, 32'h0});
		zero();
		vid(16'h5666, 16'h0002, 40'h0, 2'b10);
		settle();
		check({n_ce, n_pe}, {32'h1, 32'h0});
		check(pix_q.size(), 0);
		done("video");
		zero();
		fill(8'h00);
		// Unknown type, stepped over by its length; the filler after it must still parse
		u_host.send16(16'h0004);
		u_host.send16(16'h0045);
		u_host.send_crc(1'b0);
		fill(8'h5a);
		settle();
		check({n_ce, n_pe}, {32'h0, 32'h1});
		check(in_sync_q, 1);
		done("filler");
		zero();
		hdr(32'h0000_0100, 16'h0002, 32'h0000_0006, 1'b1);
		settle();
		check({n_sof[15:0], n_ce[15:0], in_sync_q}, {16'h0000, 16'h0001, 1'b0});
		sync(32'hffff_ffff, 16'hffff, 32'h8000_0001);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check(in_sync_q, 0);
		check({sf_len_q, reg_addr_q}, 0);
		@(posedge clk);
		nrst <= 1'b1;
		zero();
		hdr(32'h0000_0040, 16'h0003, 32'h0000_0007, 1'b0);
		settle();
		check(n_sof, 0);
		done("reset");
		sync(32'h0000_0040, 16'h0003, 32'h0000_0007);
		summarize();
	end
endmodule // test_mddi_forward_packet_parser

bind mfpp_parser mfpp_parser_chk #(.IDLE_BITS(IDLE_BITS)) u_chk (.clk(clk), .nrst(nrst),
	.mddi_data(mddi_data), .mddi_stb(mddi_stb), .in_sync_q(in_sync_q), .sof_q(sof_q),
	.sf_len_q(sf_len_q), .sf_count_q(sf_count_q), .mf_count_q(mf_count_q),
	.reg_wr_q(reg_wr_q), .reg_rd_q(reg_rd_q), .reg_addr_q(reg_addr_q),
	.reg_data_q(reg_data_q), .pix_valid_q(pix_valid_q), .pix_data_q(pix_data_q),
	.pix_18b_q(pix_18b_q), .crc_err_q(crc_err_q), .pkt_err_q(pkt_err_q));
`default_nettype wire
